/* verilog/gpp_regs.vh */
// What this block does
// - Writing the output latch changes driven value of general-purpose output pins one clock edge after the latch takes the write.
// - Reading the output latch returns the last written value, not the pin.
// - Output latch is untouched by reset; unknown at power-up until written.
// - In general-purpose output mode latch bit 0 drives low, 1 drives high.
// - Pull-up on only when enable is 1 and output buffer is off, general-purpose mode.
// - Alternate function assignment always forces the pull-up off.
// - Reset clears every pull-up enable bit.
// - Slew bit 1 is fast, 0 slow, in both pin modes.
// - Reset clears every slew bit, giving slow slew on all pins.
// - Function choice bit does nothing unless alternate function enable is set.
// - Choice 0 routes pin to first alternate function, 1 to second.
// - Multiplexer follows fixed per-pin map; reserved second functions connect to nothing.
// - With latch bit clear, direction out drives low, direction in floats.
// - Enable 0 gives pin to general-purpose logic; 1 lets chosen peripheral drive.
// - Direction 0 disables output buffer, 1 enables it, general-purpose mode.
// - Read-only pin level register shows every pin state, outputs included.
`ifndef GPP_REGS_VH
`define GPP_REGS_VH
`define GPP_ADDR_W 5
`define GPP_OFF_ALT_EN 5'h00
`define GPP_OFF_DIR 5'h04
`define GPP_OFF_LEVEL 5'h08
`define GPP_OFF_LATCH 5'h0c
`define GPP_OFF_PULLUP 5'h10
`define GPP_OFF_SLEW 5'h14
`define GPP_OFF_CHOICE 5'h18
`define GPP_RST_BYTE 8'h00
`define GPP_RDATA_PAD 24'h000000
`define GPP_RDATA_ZERO 32'h00000000
`define GPP_DEF_SECOND_MAP 8'hff
`endif

/* verilog/gpp_pin_mux.v */
`timescale 1ns/1ps
`include "gpp_regs.vh"
module gpp_pin_mux #(
  parameter WIDTH = 8,
  parameter [7:0] SECOND_PRESENT = `GPP_DEF_SECOND_MAP
) (
  // Register state.
  input wire [WIDTH-1:0] alt_en,
  input wire [WIDTH-1:0] dir,
  input wire [WIDTH-1:0] latch,
  input wire [WIDTH-1:0] pu_en,
  input wire [WIDTH-1:0] choice,
  // First and second peripheral drives.
  input wire [WIDTH-1:0] alt1_out,
  input wire [WIDTH-1:0] alt1_oe,
  input wire [WIDTH-1:0] alt2_out,
  input wire [WIDTH-1:0] alt2_oe,
  // Resolved pad controls.
  output wire [WIDTH-1:0] pad_out,
  output wire [WIDTH-1:0] pad_oe,
  output wire [WIDTH-1:0] pad_pu
);
  genvar i;
  // One slice per pin; a reserved second function yields no drive at all.
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_pin
      wire sec_ok;
      wire a_out;
      wire a_oe;
      assign sec_ok = SECOND_PRESENT[i];
      assign a_out = choice[i] ? (sec_ok & alt2_out[i]) : alt1_out[i];
      assign a_oe = choice[i] ? (sec_ok & alt2_oe[i]) : alt1_oe[i];
      // Choice only matters once the pin belongs to a peripheral.
      assign pad_out[i] = alt_en[i] ? a_out : latch[i];
      assign pad_oe[i] = alt_en[i] ? a_oe : dir[i];
      assign pad_pu[i] = ~alt_en[i] & pu_en[i] & ~dir[i];
    end
  endgenerate
endmodule

/* verilog/gpp_port.v */
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "gpp_regs.vh"
module gpp_port #(
  parameter WIDTH = 8,
  parameter [7:0] SECOND_PRESENT = `GPP_DEF_SECOND_MAP
) (
  // Clock and reset.
  input wire pclk,
  input wire presetn,
  // APB slave.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Peripheral side.
  input wire [WIDTH-1:0] alt1_out,
  input wire [WIDTH-1:0] alt1_oe,
  input wire [WIDTH-1:0] alt2_out,
  input wire [WIDTH-1:0] alt2_oe,
  output reg [WIDTH-1:0] pin_level_to_periph,
  // Pads.
  input wire [WIDTH-1:0] pad_in,
  output reg [WIDTH-1:0] pad_out,
  output reg [WIDTH-1:0] pad_oe,
  output reg [WIDTH-1:0] pad_pullup,
  output reg [WIDTH-1:0] pad_fast_slew
);
  localparam ST_IDLE = 2'b01;
  localparam ST_ACC = 2'b10;

  reg [1:0] state_q;
  reg [WIDTH-1:0] alt_function_enable_q;
  reg [WIDTH-1:0] pin_direction_bits_q;
  reg [WIDTH-1:0] port_output_latch_q;
  reg [WIDTH-1:0] port_pullup_enable_q;
  reg [WIDTH-1:0] port_slew_select_q;
  reg [WIDTH-1:0] port_alt_function_choice_q;
  reg [WIDTH-1:0] sync1_q;
  reg [WIDTH-1:0] pin_level_sample_q;
  reg [7:0] rbyte;
  reg hit;
  wire [WIDTH-1:0] mux_out;
  wire [WIDTH-1:0] mux_oe;
  wire [WIDTH-1:0] mux_pu;
  wire [`GPP_ADDR_W-1:0] addr;
  wire wr_take;
  wire lane0;

  assign addr = paddr[`GPP_ADDR_W-1:0];
  assign lane0 = pstrb[0];
  // Accesses complete in the second cycle of the access phase, pready then high.
  assign wr_take = psel & penable & pready & pwrite;

  // Address decode and read mux; the latch reads back its stored value.
  always @* begin
    rbyte = `GPP_RST_BYTE;
    hit = 1'b1;
    case (addr)
      `GPP_OFF_ALT_EN: rbyte = alt_function_enable_q;
      `GPP_OFF_DIR: rbyte = pin_direction_bits_q;
      `GPP_OFF_LEVEL: rbyte = pin_level_sample_q;
      `GPP_OFF_LATCH: rbyte = port_output_latch_q;
      `GPP_OFF_PULLUP: rbyte = port_pullup_enable_q;
      `GPP_OFF_SLEW: rbyte = port_slew_select_q;
      `GPP_OFF_CHOICE: rbyte = port_alt_function_choice_q;
      default: hit = 1'b0;
    endcase
    if (paddr[31:`GPP_ADDR_W] != 27'h0000000) begin
      hit = 1'b0;
    end
  end

  // Handshake: one wait state, then pready with data or error.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `GPP_RDATA_ZERO;
    end else begin
      case (state_q)
        ST_IDLE: begin
          pready <= 1'b0;
          pslverr <= 1'b0;
          if (psel & penable) begin
            state_q <= ST_ACC;
            pready <= 1'b1;
            pslverr <= ~hit | (pwrite & (addr == `GPP_OFF_LEVEL));
            prdata <= (hit & ~pwrite) ? {`GPP_RDATA_PAD, rbyte} : `GPP_RDATA_ZERO;
          end
        end
        ST_ACC: begin
          state_q <= ST_IDLE;
          pready <= 1'b0;
          pslverr <= 1'b0;
        end
        default: begin
          state_q <= ST_IDLE;
          pready <= 1'b0;
          pslverr <= 1'b0;
        end
      endcase
    end
  end

  // Control registers that reset clears; the pins come up as plain inputs.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alt_function_enable_q <= `GPP_RST_BYTE;
      pin_direction_bits_q <= `GPP_RST_BYTE;
      port_pullup_enable_q <= `GPP_RST_BYTE;
      port_slew_select_q <= `GPP_RST_BYTE;
      port_alt_function_choice_q <= `GPP_RST_BYTE;
    end else if (wr_take & hit & lane0) begin
      case (addr)
        `GPP_OFF_ALT_EN: alt_function_enable_q <= pwdata[WIDTH-1:0];
        `GPP_OFF_DIR: pin_direction_bits_q <= pwdata[WIDTH-1:0];
        `GPP_OFF_PULLUP: port_pullup_enable_q <= pwdata[WIDTH-1:0];
        `GPP_OFF_SLEW: port_slew_select_q <= pwdata[WIDTH-1:0];
        `GPP_OFF_CHOICE: port_alt_function_choice_q <= pwdata[WIDTH-1:0];
        default: alt_function_enable_q <= alt_function_enable_q;
      endcase
    end
  end

  // The latch has no reset on purpose, so its contents survive a reset pulse.
  always @(posedge pclk) begin
    if (wr_take & lane0 & (addr == `GPP_OFF_LATCH) & hit) begin
      port_output_latch_q <= pwdata[WIDTH-1:0];
    end
  end

  // Pad levels cross from outside through two flops before anything reads them.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= `GPP_RST_BYTE;
      pin_level_sample_q <= `GPP_RST_BYTE;
      pin_level_to_periph <= `GPP_RST_BYTE;
    end else begin
      sync1_q <= pad_in;
      pin_level_sample_q <= sync1_q;
      pin_level_to_periph <= sync1_q;
    end
  end

  gpp_pin_mux #(
    .WIDTH(WIDTH),
    .SECOND_PRESENT(SECOND_PRESENT)
  ) u_mux (
    .alt_en(alt_function_enable_q),
    .dir(pin_direction_bits_q),
    .latch(port_output_latch_q),
    .pu_en(port_pullup_enable_q),
    .choice(port_alt_function_choice_q),
    .alt1_out(alt1_out),
    .alt1_oe(alt1_oe),
    .alt2_out(alt2_out),
    .alt2_oe(alt2_oe),
    .pad_out(mux_out),
    .pad_oe(mux_oe),
    .pad_pu(mux_pu)
  );

  // Registered pad drive: a latch write reaches the pin one edge later.
  // Before the first latch write pad_out may be unknown, as the latch is.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_oe <= `GPP_RST_BYTE;
      pad_pullup <= `GPP_RST_BYTE;
      pad_fast_slew <= `GPP_RST_BYTE;
      pad_out <= `GPP_RST_BYTE;
    end else begin
      pad_oe <= mux_oe;
      pad_pullup <= mux_pu;
      pad_fast_slew <= port_slew_select_q;
      pad_out <= mux_out;
    end
  end
endmodule

/* tb/gpp_port_monitor.sv */
`timescale 1ns/1ps
module gpp_port_monitor (
  // Clock, reset and bus.
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Pads and pin level.
  input wire [7:0] pad_in,
  input wire [7:0] pin_level_to_periph,
  input wire [7:0] pad_oe,
  input wire [7:0] pad_pullup,
  input wire [7:0] pad_fast_slew
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Bus answers come one cycle long, after one wait state.
  AST_RDY_PULSE: assert property (pready |=> !pready) else $error("pready too long");
  AST_RDY_WAIT: assert property (pready |-> psel && penable && $past(psel && penable))
    else $error("pready without wait state");
  AST_ERR_PAIR: assert property (pslverr |-> pready) else $error("pslverr alone");
  AST_RD_UPPER: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  AST_BAD_ADDR: assert property (pready && paddr[31:5] != 0 |-> pslverr && prdata == 0)
    else $error("unmapped address accepted");
  AST_LVL_RO: assert property (pready && pwrite && paddr == 32'h8 |-> pslverr)
    else $error("level write accepted");
  AST_PU_OFF: assert property ((pad_pullup & pad_oe) == 8'h00)
    else $error("pull-up on a driven pin");
  AST_RST_CLR: assert property ($rose(presetn) |-> pad_pullup == 0 && pad_fast_slew == 0)
    else $error("pull-up or slew left after reset");
  // The guards skip edges whose history still reaches into reset.
  AST_SYNC: assert property ($past(presetn, 2) && $past(presetn)
    |-> pin_level_to_periph == $past(pad_in, 2)) else $error("level lag wrong");
  AST_SLEW_WR: assert property ($past(presetn, 2) && $past(presetn) && $changed(pad_fast_slew)
    |-> $past(pready && pwrite && paddr == 32'h14, 2)) else $error("slew moved");
  cover property (pready && pslverr);
  cover property (pready && pwrite);
  cover property (pad_pullup != 8'h00);
endmodule
bind gpp_port gpp_port_monitor i_mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .pad_in, .pin_level_to_periph, .pad_oe, .pad_pullup,
  .pad_fast_slew);

/* tb/gpp_far.sv */
`timescale 1ns/1ps
module gpp_far (
  // Clock and peripheral change request.
  input wire pclk,
  input wire roll,
  // Pad controls.
  input wire [7:0] pad_out,
  input wire [7:0] pad_oe,
  input wire [7:0] pad_pullup,
  // Pin levels and peripheral drives, alt1 out/oe then alt2 out/oe.
  output logic [7:0] pad_in = 8'h00,
  output logic [31:0] alt = 32'h0
);
  // A floating pin shows the inverse of its last level, so a stale value never passes.
  always @(posedge pclk) begin
    pad_in <= (pad_oe & pad_out) | (~pad_oe & (pad_pullup | ~pad_in));
    if (roll)
      alt <= $urandom;
  end
endmodule

/* tb/tb_gpio_port_pin_control.sv */
`timescale 1ns/1ps
`include "gpp_regs.vh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; \
  $display("ERROR %0t got %h exp %h", $time, (a), (b)); end end
module tb_gpio_port_pin_control;
  localparam [7:0] SP = 8'h0f;
  logic pclk, presetn, psel, penable, pwrite, roll, e, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, r, alt;
  logic [3:0] pstrb;
  logic [7:0] pad_in, pad_out, pad_oe, pad_pullup, pad_fast_slew, lvl, lt, dr, pu, sl, al, ch, m;
  logic [23:0] x;
  int num_errors = 0, checked = 0, cyc = 0, i;
  gpp_port #(.SECOND_PRESENT(SP)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .alt1_out(alt[31:24]), .alt1_oe(alt[23:16]),
    .alt2_out(alt[15:8]), .alt2_oe(alt[7:0]), .pin_level_to_periph(lvl), .pad_in, .pad_out,
    .pad_oe, .pad_pullup, .pad_fast_slew);
  gpp_far i_far (.pclk, .roll, .pad_out, .pad_oe, .pad_pullup, .pad_in, .alt);
  // Free-running clock and a cap on run length.
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      close_out;
    end
  end
  task close_out;
    if (num_errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // One bus transfer; an idle edge follows so back-to-back calls never collide.
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
    if (n >= 50)
      num_errors++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wr(input logic [4:0] a, input logic [7:0] d);
    apb(1'b1, {27'h0, a}, {24'h0, d});
  endtask
  task rd(input logic [4:0] a);
    apb(1'b0, {27'h0, a}, 32'h0);
  endtask
  // Expected pad oe, out and pull-up for one configuration.
  function automatic [23:0] ex(input [7:0] a, d, l, p, c, input [31:0] v);
    logic [7:0] s1, s2;
    s1 = a & ~c;
    s2 = a & c & SP;
    ex[23:16] = (~a & d) | (s1 & v[23:16]) | (s2 & v[7:0]);
    ex[15:8] = (~a & l) | (s1 & v[31:24]) | (s2 & v[15:8]);
    ex[7:0] = ~a & p & ~d;
  endfunction
  initial begin
    {presetn, psel, penable, pwrite, roll, paddr, pwdata, pstrb} = {69'h0, 4'hf};
    void'($urandom(32'h92a74009));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (i = 0; i < 40; i++) begin
      {lt, dr, pu, sl} = $urandom;
      {al, ch} = 16'($urandom);
      if (i % 4 == 1) lt = 8'h00;
      if (i % 4 != 0) ch = ch & SP;
      roll <= 1'b1;
      @(posedge pclk);
      roll <= 1'b0;
      wr(`GPP_OFF_LATCH, lt);
      wr(`GPP_OFF_PULLUP, pu);
      wr(`GPP_OFF_SLEW, sl);
      wr(`GPP_OFF_CHOICE, ch);
      wr(`GPP_OFF_ALT_EN, al);
      wr(`GPP_OFF_DIR, dr);
      repeat (4) @(posedge pclk);
      x = ex(al, dr, lt, pu, ch, alt);
      m = x[23:16] | x[7:0];
      `CHK(pad_oe, x[23:16])
      `CHK(pad_out & x[23:16], x[15:8] & x[23:16])
      `CHK(pad_pullup, x[7:0])
      `CHK(pad_fast_slew, sl)
      rd(`GPP_OFF_LATCH);
      `CHK({e, r}, {1'b0, 24'h0, lt})
      rd(`GPP_OFF_LEVEL);
      `CHK(r[7:0] & m, (x[15:8] | x[7:0]) & m)
    end
    // Mid-run reset: the latch survives, pull-up and slew clear.
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`GPP_OFF_LATCH);
    `CHK(r, {24'h0, lt})
    rd(`GPP_OFF_PULLUP);
    `CHK(r, 32'h0)
    rd(`GPP_OFF_SLEW);
    `CHK(r, 32'h0)
    apb(1'b0, 32'h20, 32'h0);
    `CHK({e, r}, {1'b1, 32'h0})
    wr(`GPP_OFF_LEVEL, 8'hff);
    `CHK(e, 1'b1)
    pstrb <= 4'h0;
    wr(`GPP_OFF_LATCH, ~lt);
    pstrb <= 4'hf;
    rd(`GPP_OFF_LATCH);
    `CHK(r, {24'h0, lt})
    close_out;
  end
endmodule
